// *** rtl/pbc_pkg.sv ***
/*
 pbc_pkg: constants and types for the pll base clock select control block.
 assumes a 32-bit classic wishbone register bus with byte addressing.
*/
package pbc_pkg;
   // register byte offsets
   localparam logic [3:0] OFS_CONTROL = 4'h0;
   localparam logic [3:0] OFS_BANDWIDTH = 4'h4;
   localparam logic [3:0] OFS_PROGRAM = 4'h8;

   // control register fields
   localparam int CTL_IRQ_EN = 7;
   localparam int CTL_FLAG = 6;
   localparam int CTL_POWER = 5;
   localparam int CTL_BCS = 4;
   localparam logic [3:0] CTL_LOW_ONES = 4'hf;

   // bandwidth register fields
   localparam int BW_AUTO = 7;
   localparam int BW_LOCK = 6;

   // programming register fields
   localparam int PRG_MUL_LSB = 4;
   localparam int PRG_RANGE_LSB = 0;

   // reset values
   localparam logic RST_POWER = 1'b1;
   localparam logic [3:0] RST_MUL = 4'h6;
   localparam logic [3:0] RST_RANGE = 4'h6;

   // source edges waited for on a switch, per source
   localparam logic [1:0] SWITCH_EDGES = 2'h3;

   typedef enum logic {
      PBC_SRC_CRYSTAL,
      PBC_SRC_VCO
   } pbc_src_t;

   typedef enum logic {
      PBC_RUN,
      PBC_SWITCH
   } pbc_state_t;

   typedef struct packed {
      logic [3:0] adr;
      logic we;
      logic sel0;
      logic [7:0] dat;
   } pbc_wb_req_t;
endpackage : pbc_pkg

// *** rtl/pbc_top.sv ***
/*
 pbc_top: base clock selection, divide by two and pll control interlocks.
 assumes crystal, vco and lock inputs are sampled as levels on clk_sys, which
 must run well above both source clocks; osc_enable_in comes from system control.
*/
// Added by the designer: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module pbc_top (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic crystal_clock,
   input wire logic vco_clock,
   input wire logic lock_detect,
   input wire logic osc_enable_in,
   output logic crystal_clock_out,
   output logic base_clock_out,
   output logic clockgen_irq,
   output logic pll_enable,
   output logic [3:0] feedback_multiplier,
   output logic [3:0] vco_range_factor
);
   logic lock_irq_enable;
   logic lock_change_flag;
   logic pll_power_on;
   logic base_clock_select;
   logic auto_bandwidth;
   logic [3:0] mul_field;
   logic [3:0] range_field;
   logic xtal_q;
   logic xtal_prev;
   logic vco_q;
   logic vco_prev;
   logic lock_q;
   logic lock_prev;
   logic xtal_edge;
   logic vco_edge;
   logic lock_toggle;
   logic range_zero;
   logic bus_req;
   logic wr_ctl;
   logic wr_bw;
   logic wr_prg;
   logic rd_ctl;
   logic adr_hit;
   logic src_differs;
   logic switch_done;
   logic active_edge;
   pbc_pkg::pbc_wb_req_t req;
   pbc_pkg::pbc_state_t state;
   pbc_pkg::pbc_src_t active_src;
   logic [1:0] xtal_cnt;
   logic [1:0] vco_cnt;
   logic [7:0] ctl_view;
   logic [7:0] bw_view;
   logic [7:0] next_rdata;

   assign req = '{adr: wb_adr_i[3:0], we: wb_we_i, sel0: wb_sel_i[0], dat: wb_dat_i[7:0]};
   // one access per handshake: the request is taken in the cycle before ack, not in the ack cycle
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // upper address bits must be clear, so an alias cannot write or clear the flag
   assign adr_hit = wb_adr_i[31:4] == 28'h000_0000;
   assign wr_ctl = bus_req && adr_hit && req.we && req.sel0 && req.adr == pbc_pkg::OFS_CONTROL;
   assign wr_bw = bus_req && adr_hit && req.we && req.sel0 && req.adr == pbc_pkg::OFS_BANDWIDTH;
   assign wr_prg = bus_req && adr_hit && req.we && req.sel0 && req.adr == pbc_pkg::OFS_PROGRAM;
   assign rd_ctl = bus_req && adr_hit && !req.we && req.adr == pbc_pkg::OFS_CONTROL;

   assign range_zero = range_field == 4'h0;
   assign xtal_edge = xtal_q && !xtal_prev;
   assign vco_edge = vco_q && !vco_prev;
   assign lock_toggle = lock_q != lock_prev;

   // switch helpers: base clock only moves in run state on the active source
   assign src_differs = (active_src == pbc_pkg::PBC_SRC_VCO) != base_clock_select;
   assign switch_done = xtal_cnt == pbc_pkg::SWITCH_EDGES && vco_cnt == pbc_pkg::SWITCH_EDGES;
   assign active_edge = (active_src == pbc_pkg::PBC_SRC_VCO) ? vco_edge : xtal_edge;

   // input sampling for edge detection; the crystal is gated by the oscillator enable
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         xtal_q <= 1'b0;
         xtal_prev <= 1'b0;
      end else begin
         xtal_q <= crystal_clock && osc_enable_in;
         xtal_prev <= xtal_q;
      end
   end

   // vco seen only while the pll is enabled
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         vco_q <= 1'b0;
         vco_prev <= 1'b0;
      end else begin
         vco_q <= vco_clock && pll_enable;
         vco_prev <= vco_q;
      end
   end

   // lock seen only in automatic mode with the pll running
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         lock_q <= 1'b0;
         lock_prev <= 1'b0;
      end else begin
         lock_q <= lock_detect && auto_bandwidth && pll_enable;
         lock_prev <= lock_q;
      end
   end

   // base select judged against the old power and range, so off to vco takes two writes
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         base_clock_select <= 1'b0;
      end else if (!osc_enable_in || range_zero || !pll_power_on) begin
         base_clock_select <= 1'b0;
      end else if (wr_ctl) begin
         base_clock_select <= req.dat[pbc_pkg::CTL_BCS];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pll_power_on <= pbc_pkg::RST_POWER;
      end else if (wr_ctl) begin
         pll_power_on <= req.dat[pbc_pkg::CTL_POWER] || base_clock_select;
      end
   end

   // interrupt enable held clear in manual bandwidth mode, writable only in automatic mode
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         lock_irq_enable <= 1'b0;
      end else if (!auto_bandwidth) begin
         lock_irq_enable <= 1'b0;
      end else if (wr_ctl) begin
         lock_irq_enable <= req.dat[pbc_pkg::CTL_IRQ_EN];
      end
   end

   // a toggle in the clearing read cycle keeps the flag set
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         lock_change_flag <= 1'b0;
      end else if (!auto_bandwidth) begin
         lock_change_flag <= 1'b0;
      end else if (lock_toggle) begin
         lock_change_flag <= 1'b1;
      end else if (rd_ctl) begin
         lock_change_flag <= 1'b0;
      end
   end

   // level request, dropped at once on stop
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         clockgen_irq <= 1'b0;
      end else begin
         clockgen_irq <= lock_change_flag && lock_irq_enable && osc_enable_in;
      end
   end

   // bandwidth mode
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         auto_bandwidth <= 1'b0;
      end else if (wr_bw) begin
         auto_bandwidth <= req.dat[pbc_pkg::BW_AUTO];
      end
   end

   // programming register, locked while pll_power_on is set
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mul_field <= pbc_pkg::RST_MUL;
         range_field <= pbc_pkg::RST_RANGE;
      end else if (wr_prg && !pll_power_on) begin
         mul_field <= req.dat[pbc_pkg::PRG_MUL_LSB +: 4];
         range_field <= req.dat[pbc_pkg::PRG_RANGE_LSB +: 4];
      end
   end

   // analog side controls, each registered so the pins never glitch
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pll_enable <= 1'b0;
      end else begin
         pll_enable <= pll_power_on && !range_zero && osc_enable_in;
      end
   end

   // a zero multiplier is passed on as one
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         feedback_multiplier <= 4'h0;
      end else begin
         feedback_multiplier <= (mul_field == 4'h0) ? 4'h1 : mul_field;
      end
   end

   // range copy; a zero range also keeps pll_enable low
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         vco_range_factor <= 4'h0;
      end else begin
         vco_range_factor <= range_field;
      end
   end

   // crystal out follows the oscillator enable
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         crystal_clock_out <= 1'b0;
      end else begin
         crystal_clock_out <= crystal_clock && osc_enable_in;
      end
   end

   // source switch: base clock frozen until both sources have ticked, or until a stopped vco forces a fall back to crystal
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state <= pbc_pkg::PBC_RUN;
         active_src <= pbc_pkg::PBC_SRC_CRYSTAL;
      end else if (!osc_enable_in) begin
         state <= pbc_pkg::PBC_RUN;
         active_src <= pbc_pkg::PBC_SRC_CRYSTAL;
      end else begin
         unique case (state)
            pbc_pkg::PBC_RUN: begin
               if (src_differs) begin
                  state <= pbc_pkg::PBC_SWITCH;
               end
            end
            pbc_pkg::PBC_SWITCH: begin
               // a dead vco would stall here; vco stays on while selected
               if (switch_done) begin
                  state <= pbc_pkg::PBC_RUN;
                  active_src <= base_clock_select ? pbc_pkg::PBC_SRC_VCO : pbc_pkg::PBC_SRC_CRYSTAL;
               end else if (!base_clock_select && !pll_enable) begin
                  // pll_enable low stops the vco: fall back without waiting on it
                  state <= pbc_pkg::PBC_RUN;
                  active_src <= pbc_pkg::PBC_SRC_CRYSTAL;
               end
            end
         endcase
      end
   end

   // crystal edges counted while switching, saturating at the wait length
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         xtal_cnt <= 2'h0;
      end else if (!osc_enable_in || state == pbc_pkg::PBC_RUN) begin
         xtal_cnt <= 2'h0;
      end else if (xtal_edge && xtal_cnt != pbc_pkg::SWITCH_EDGES) begin
         xtal_cnt <= xtal_cnt + 2'h1;
      end
   end

   // vco edges counted the same way
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         vco_cnt <= 2'h0;
      end else if (!osc_enable_in || state == pbc_pkg::PBC_RUN) begin
         vco_cnt <= 2'h0;
      end else if (vco_edge && vco_cnt != pbc_pkg::SWITCH_EDGES) begin
         vco_cnt <= vco_cnt + 2'h1;
      end
   end

   // divide by two on rising source edges only, which keeps the duty at half
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         base_clock_out <= 1'b0;
      end else if (!osc_enable_in) begin
         base_clock_out <= 1'b0;
      end else if (state == pbc_pkg::PBC_RUN && !src_differs && active_edge) begin
         base_clock_out <= !base_clock_out;
      end
   end

   always_comb begin
      ctl_view = {lock_irq_enable, lock_change_flag, pll_power_on, base_clock_select, pbc_pkg::CTL_LOW_ONES};
      bw_view = 8'h00;
      bw_view[pbc_pkg::BW_AUTO] = auto_bandwidth;
      bw_view[pbc_pkg::BW_LOCK] = lock_q;
      unique case (req.adr)
         pbc_pkg::OFS_CONTROL: next_rdata = ctl_view;
         pbc_pkg::OFS_BANDWIDTH: next_rdata = bw_view;
         pbc_pkg::OFS_PROGRAM: next_rdata = {mul_field, range_field};
         default: next_rdata = 8'h00;
      endcase
   end

   // wishbone slave: ack one cycle after request, low again in the next
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req;
      end
   end

   // read data stands only in the ack cycle; unmapped reads give zero
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (bus_req && !req.we && adr_hit) begin
         wb_dat_o <= {24'h00_0000, next_rdata};
      end else begin
         wb_dat_o <= 32'h0000_0000;
      end
   end
endmodule : pbc_top

// *** verif/pbc_far_model.sv ***
/* pbc_far_model: crystal and vco source clocks for pbc_top.
 assumes clk_sys runs well above both sources. */
`timescale 1ns/1ps
module pbc_far_model #(parameter int XH = 3, parameter int VH = 2) (
   input wire logic clk_sys,
   input wire logic pll_enable,
   output logic crystal_clock,
   output logic vco_clock
);
   int xc = 0;
   int vc = 0;
   initial begin
      crystal_clock = 1'b0;
      vco_clock = 1'b0;
   end
   always @(posedge clk_sys) begin
      xc <= (xc == XH - 1) ? 0 : xc + 1;
      if (xc == XH - 1) crystal_clock <= ~crystal_clock;
   end
   // vco stands still while the pll is off
   always @(posedge clk_sys) begin
      vc <= (vc == VH - 1) ? 0 : vc + 1;
      if (pll_enable && vc == VH - 1) vco_clock <= ~vco_clock;
   end
endmodule : pbc_far_model

// *** verif/pbc_checker.sv ***
/* pbc_checker: port properties of pbc_top.
 assumes rising clk_sys and active high rst. */
`timescale 1ns/1ps
module pbc_checker (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic osc_enable_in,
   input wire logic crystal_clock_out,
   input wire logic base_clock_out,
   input wire logic clockgen_irq,
   input wire logic pll_enable,
   input wire logic [3:0] feedback_multiplier,
   input wire logic [3:0] vco_range_factor
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic rd;
   logic rd_ctl;
   assign rd = wb_ack_o && !wb_we_i;
   assign rd_ctl = rd && wb_adr_i == 32'h0;
   property p_stop; !osc_enable_in |=> !base_clock_out && !clockgen_irq && !crystal_clock_out; endproperty
   a_stop: assert property (p_stop) else $error("outputs not low on stop");
   property p_off; !osc_enable_in |=> !pll_enable; endproperty
   a_off: assert property (p_off) else $error("pll enabled on stop");
   property p_mul; !$past(rst) |-> feedback_multiplier != 4'h0; endproperty
   a_mul: assert property (p_mul) else $error("multiplier zero");
   property p_range; vco_range_factor == 4'h0 |-> !pll_enable; endproperty
   a_range: assert property (p_range) else $error("pll on with zero range");
   property p_low; rd_ctl |-> wb_dat_o[3:0] == 4'hf; endproperty
   a_low: assert property (p_low) else $error("low bits not ones");
   property p_sel; rd_ctl && wb_dat_o[4] |-> wb_dat_o[5] && vco_range_factor != 4'h0; endproperty
   a_sel: assert property (p_sel) else $error("select set illegally");
   property p_lock; rd && wb_adr_i == 32'h4 && !wb_dat_o[7] |-> !wb_dat_o[6]; endproperty
   a_lock: assert property (p_lock) else $error("lock shown in manual");
   property p_irq; clockgen_irq |-> $past(osc_enable_in); endproperty
   a_irq: assert property (p_irq) else $error("irq while stopped");
   property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("bad ack timing");
   c_vco: cover property (rd_ctl && wb_dat_o[4]);
   c_irq: cover property (clockgen_irq);
   c_stop: cover property (!osc_enable_in);
endmodule : pbc_checker
bind pbc_top pbc_checker pbc_checker_i (.*);

// *** verif/pbc_top_test.sv ***
/* pbc_top_test: self-checking bench for pbc_top.
 assumes pbc_far_model and the bound checker. */
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; $display("BAD %0t %h %h", $time, a, b); end end
module pbc_top_test;
   localparam int XH = 3;
   localparam int VH = 2;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, lock_detect = 1'b0, osc_enable_in = 1'b1;
   logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o;
   logic [3:0] wb_sel_i = 4'h1, feedback_multiplier, vco_range_factor;
   logic wb_ack_o, crystal_clock, vco_clock, crystal_clock_out, base_clock_out, clockgen_irq, pll_enable;
   logic [7:0] q, r;
   int n_fail = 0, checks_done = 0, cyc_n = 0, p;
   always #20 clk_sys = ~clk_sys;
   pbc_top pbc_top_i (.*);
   pbc_far_model #(.XH(XH), .VH(VH)) pbc_far_model_i (.clk_sys(clk_sys), .pll_enable(pll_enable),
      .crystal_clock(crystal_clock), .vco_clock(vco_clock));
   task automatic complete_run();
      if (n_fail == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : complete_run
   always @(posedge clk_sys) begin
      cyc_n++;
      if (cyc_n == 20000) begin
         n_fail++;
         complete_run();
      end
   end
   task automatic bus(input logic we, input logic [31:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= {24'h0, d};
      do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
      q = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : bus
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [31:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      `CHK(q, e)
   endtask : rd
   // base period in clk_sys cycles: two source periods
   function automatic int exp_per(input logic vco);
      return vco ? 4 * VH : 4 * XH;
   endfunction : exp_per
   // first interval after a switch may include the frozen stretch
   task automatic per();
      repeat (2) @(posedge base_clock_out);
      p = cyc_n;
      @(posedge base_clock_out);
      p = cyc_n - p;
   endtask : per
   initial begin
      r = 8'($urandom(82));
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      rd(32'h0, 8'h2f);
      rd(32'h4, 8'h00);
      rd(32'h10, 8'h00);
      wr(32'h8, 8'($urandom));
      rd(32'h8, 8'h66);
      wr(32'h0, 8'h00);
      rd(32'h0, 8'h0f);
      wr(32'h0, 8'h30);
      rd(32'h0, 8'h2f);
      wr(32'h0, 8'h30);
      rd(32'h0, 8'h3f);
      `CHK(pll_enable, 1'b1)
      per();
      `CHK(p, exp_per(1'b1))
      wr(32'h0, 8'h00);
      rd(32'h0, 8'h2f);
      per();
      `CHK(p, exp_per(1'b0))
      wr(32'h0, 8'h00);
      r = {4'h0, 4'h1 + 4'($urandom % 15)};
      wr(32'h8, r);
      rd(32'h8, r);
      `CHK(feedback_multiplier, 4'h1)
      `CHK(vco_range_factor, r[3:0])
      wr(32'h8, 8'h00);
      wr(32'h0, 8'h20);
      wr(32'h0, 8'h30);
      rd(32'h0, 8'h2f);
      `CHK(pll_enable, 1'b0)
      wr(32'h0, 8'h00);
      wr(32'h8, 8'h66);
      wr(32'h0, 8'ha0);
      rd(32'h0, 8'h2f);
      lock_detect <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rd(32'h0, 8'h2f);
      wr(32'h4, 8'h80);
      rd(32'h4, 8'hc0);
      bus(1'b0, 32'h0, 8'h00);
      wr(32'h0, 8'ha0);
      repeat (2) begin
         repeat (1 + $urandom % 4) @(posedge clk_sys);
         lock_detect <= ~lock_detect;
         repeat (4) @(posedge clk_sys);
         `CHK(clockgen_irq, 1'b1)
         wr(32'h14, 8'h00);
         rd(32'h10, 8'h00);
         rd(32'h0, 8'hef);
         @(posedge clk_sys);
         `CHK(clockgen_irq, 1'b0)
      end
      wr(32'h0, 8'hb0);
      @(posedge clk_sys);
      osc_enable_in <= 1'b0;
      repeat (3) @(posedge clk_sys);
      `CHK({base_clock_out, crystal_clock_out, clockgen_irq}, 3'h0)
      osc_enable_in <= 1'b1;
      bus(1'b0, 32'h0, 8'h00);
      `CHK(q[5:4], 2'h2)
      complete_run();
   end
endmodule : pbc_top_test
